// ==== include/refid_pkg.sv ====
// constants for the remote reference / identification register slice
// assumes a serial front end that turns bus frames into byte-wide register strobes
package refid_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CHAN_ENABLE = 8'h35;
    localparam logic [7:0] ADDR_DIODE_FAULT = 8'h36;
    localparam logic [7:0] ADDR_ALARM_MASK = 8'h39;
    localparam logic [7:0] ADDR_REF2_HIGH = 8'h44;
    localparam logic [7:0] ADDR_REF2_LOW = 8'h45;
    localparam logic [7:0] ADDR_REF3_HIGH = 8'h46;
    localparam logic [7:0] ADDR_REF3_LOW = 8'h47;
    localparam logic [7:0] ADDR_MAKER_ID = 8'h50;
    localparam logic [7:0] ADDR_SILICON_REV = 8'h51;

    // ----------------------------------------
    // reset values and fields
    // ----------------------------------------
    localparam logic [7:0] RST_REF_HIGH = 8'h00;
    localparam logic [3:0] RST_REF_FRAC = 4'h0;
    localparam logic [3:0] RST_CHAN_ENABLE = 4'hf;
    localparam logic [3:0] RST_ALARM_MASK = 4'h0;
    localparam logic [3:1] RST_DIODE_FAULT = 3'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int FRAC_MSB = 7;
    localparam int FRAC_LSB = 4;
    localparam int TEMP_W = 12;

    // ----------------------------------------
    // measurement sequence states
    // ----------------------------------------
    typedef enum logic [3:0] {
        CH_LOCAL = 4'b0001,
        CH_REMOTE1 = 4'b0010,
        CH_REMOTE2 = 4'b0100,
        CH_REMOTE3 = 4'b1000
    } chan_t;

    // sign + 64..1 integer byte followed by half..sixteenth nibble
    function automatic logic signed [TEMP_W-1:0] join_temp(input logic [7:0] high, input logic [3:0] frac);
        join_temp = {high, frac};
    endfunction
endpackage

// ==== core/fault_watch.sv ====
// diode fault status for the three remote channels and alarm gating for all four channels
// assumes open/short detector levels arrive asynchronously from the analog front end
`timescale 1ns/100ps
module fault_watch
    import refid_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [3:1] i_diode_open,
    input wire logic [3:1] i_diode_short,
    input wire logic [3:1] i_chan_enable,
    input wire logic i_fault_wr,
    input wire logic [3:1] i_fault_wdata,
    input wire logic [3:0] i_thermal_fault,
    input wire logic [3:0] i_alarm_mask,
    output logic [3:1] o_diode_fault,
    output logic o_thermal_alarm_output
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [3:1] open_meta;
    logic [3:1] open_sync;
    logic [3:1] short_meta;
    logic [3:1] short_sync;
    logic [3:1] detect;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            open_meta <= RST_DIODE_FAULT;
            open_sync <= RST_DIODE_FAULT;
            short_meta <= RST_DIODE_FAULT;
            short_sync <= RST_DIODE_FAULT;
        end else begin
            open_meta <= i_diode_open;
            open_sync <= open_meta;
            short_meta <= i_diode_short;
            short_sync <= short_meta;
        end
    end

    // disabled channels get no fault detection
    assign detect = (open_sync | short_sync) & i_chan_enable;

    // ----------------------------------------
    // sticky fault status
    // ----------------------------------------
    // writing zero clears a bit; a new detection in the same cycle wins
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_diode_fault <= RST_DIODE_FAULT;
        end else if (i_fault_wr) begin
            o_diode_fault <= (o_diode_fault & i_fault_wdata) | detect;
        end else begin
            o_diode_fault <= o_diode_fault | detect;
        end
    end

    // ----------------------------------------
    // alarm gating
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_thermal_alarm_output <= 1'b0;
        end else begin
            o_thermal_alarm_output <= |((i_thermal_fault | {o_diode_fault, 1'b0}) & ~i_alarm_mask);
        end
    end

    AST_FAULT_STICKS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (|detect) |=> ((o_diode_fault & $past(detect)) == $past(detect)))
        else $error("detected diode fault not latched");
    AST_MASK_SILENCES: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (((i_thermal_fault | {o_diode_fault, 1'b0}) & ~i_alarm_mask) == 4'h0) |=> !o_thermal_alarm_output)
        else $error("alarm raised by a masked channel");
    AST_UNMASKED_RAISES: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ((o_diode_fault[2] && !i_alarm_mask[2]) [*2]) |-> o_thermal_alarm_output)
        else $error("unmasked diode fault gave no alarm");
endmodule

// ==== core/remote_reference_and_id_regs.sv ====
// reference temperature, channel enable, mask and identification registers
// assumes the serial bus front end gives one-cycle read/write strobes with a byte address
`timescale 1ns/100ps
// Functional notes
// - each reference upper byte is sign then 64..1 degree weights, read/write, reset zero.
// - each reference lower byte keeps half..sixteenth degree in its upper nibble, lower nibble reads zero.
// - channel 2 and channel 3 each own an upper/lower reference pair at consecutive addresses, upper first.
// - each channel's reference decides what is written into the highest-temperature tracking registers.
// - toggling the extended-format setting leaves stored references untouched.
// - an eight-bit register returns the maker identification code.
// - the next eight-bit register returns the silicon revision code.
// - an open or shorted diode on an enabled remote channel is reported as a diode fault.
// - a faulted remote channel is skipped in the measurement sequence.
// - a masked channel never raises the thermal alarm output, diode faults included.
// - diode fault status uses bits 3..1 per remote channel and bit 0 reads zero.
// - a one in a channel's mask bit suppresses its alarm, default zero.
module remote_reference_and_id_regs
    import refid_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'ha5, // value arbitrary
    parameter logic [7:0] REVISION_CODE = 8'h03, // value arbitrary
    parameter int MEAS_W = TEMP_W
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_extended_format,
    input wire logic [3:1] i_remote_diode_open,
    input wire logic [3:1] i_remote_diode_short,
    input wire logic [3:0] i_thermal_fault,
    input wire logic i_conv_done,
    input wire logic i_meas_valid,
    input wire logic [3:0] i_meas_chan,
    input wire logic signed [MEAS_W-1:0] i_meas_temp,
    output logic [3:0] o_meas_chan,
    output logic o_highest_load,
    output logic [3:0] o_highest_chan,
    output logic signed [TEMP_W-1:0] o_highest_value,
    output logic signed [TEMP_W-1:0] o_ref_temp2,
    output logic signed [TEMP_W-1:0] o_ref_temp3,
    output logic o_thermal_alarm_output
);
    // the highest-feed compare needs both operands at one width
    if (MEAS_W != TEMP_W) begin : g_width_check
        $error("measured temperature width must match the reference width");
    end

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] ref2_high;
    logic [3:0] ref2_frac;
    logic [7:0] ref3_high;
    logic [3:0] ref3_frac;
    logic [3:0] chan_enable;
    logic [3:0] alarm_mask;
    logic [3:1] diode_fault;
    logic fault_wr;
    chan_t seq_state;
    chan_t next_seq_state;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // the stored bytes are never rescaled here; format is the host's concern
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref2_high <= RST_REF_HIGH;
            ref2_frac <= RST_REF_FRAC;
            ref3_high <= RST_REF_HIGH;
            ref3_frac <= RST_REF_FRAC;
        end else if (i_reg_wr) begin
            if (hit(i_reg_addr, ADDR_REF2_HIGH)) begin
                ref2_high <= i_reg_wdata;
            end
            if (hit(i_reg_addr, ADDR_REF2_LOW)) begin
                ref2_frac <= i_reg_wdata[FRAC_MSB:FRAC_LSB];
            end
            if (hit(i_reg_addr, ADDR_REF3_HIGH)) begin
                ref3_high <= i_reg_wdata;
            end
            if (hit(i_reg_addr, ADDR_REF3_LOW)) begin
                ref3_frac <= i_reg_wdata[FRAC_MSB:FRAC_LSB];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            chan_enable <= RST_CHAN_ENABLE;
            alarm_mask <= RST_ALARM_MASK;
        end else if (i_reg_wr) begin
            if (hit(i_reg_addr, ADDR_CHAN_ENABLE)) begin
                chan_enable <= i_reg_wdata[3:0];
            end
            if (hit(i_reg_addr, ADDR_ALARM_MASK)) begin
                alarm_mask <= i_reg_wdata[3:0];
            end
        end
    end

    assign fault_wr = i_reg_wr && hit(i_reg_addr, ADDR_DIODE_FAULT);

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // identification writes are dropped so the codes always read back
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= READ_UNMAPPED;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    ADDR_CHAN_ENABLE: o_reg_rdata <= {4'h0, chan_enable};
                    ADDR_DIODE_FAULT: o_reg_rdata <= {4'h0, diode_fault, 1'b0};
                    ADDR_ALARM_MASK: o_reg_rdata <= {4'h0, alarm_mask};
                    ADDR_REF2_HIGH: o_reg_rdata <= ref2_high;
                    ADDR_REF2_LOW: o_reg_rdata <= {ref2_frac, 4'h0};
                    ADDR_REF3_HIGH: o_reg_rdata <= ref3_high;
                    ADDR_REF3_LOW: o_reg_rdata <= {ref3_frac, 4'h0};
                    ADDR_MAKER_ID: o_reg_rdata <= MAKER_CODE;
                    ADDR_SILICON_REV: o_reg_rdata <= REVISION_CODE;
                    default: o_reg_rdata <= READ_UNMAPPED;
                endcase
            end
        end
    end

    // ----------------------------------------
    // fault status and alarm
    // ----------------------------------------
    fault_watch u_fault_watch (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_diode_open(i_remote_diode_open),
        .i_diode_short(i_remote_diode_short),
        .i_chan_enable(chan_enable[3:1]),
        .i_fault_wr(fault_wr),
        .i_fault_wdata(i_reg_wdata[3:1]),
        .i_thermal_fault(i_thermal_fault),
        .i_alarm_mask(alarm_mask),
        .o_diode_fault(diode_fault),
        .o_thermal_alarm_output(o_thermal_alarm_output)
    );

    // ----------------------------------------
    // measurement sequence
    // ----------------------------------------
    // searches forward from the current channel; holds if nothing is usable
    function automatic chan_t step_channel(input chan_t cur, input logic [3:0] usable);
        logic [3:0] rot;
        step_channel = cur;
        rot = {cur[2:0], cur[3]};
        for (int i = 0; i < 4; i++) begin
            if ((rot & usable) != 4'h0) begin
                step_channel = chan_t'(rot);
                break;
            end
            rot = {rot[2:0], rot[3]};
        end
    endfunction

    always_comb begin
        next_seq_state = step_channel(seq_state, chan_enable & ~{diode_fault, 1'b0});
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seq_state <= CH_LOCAL;
        end else if (i_conv_done) begin
            case (next_seq_state)
                CH_LOCAL, CH_REMOTE1, CH_REMOTE2, CH_REMOTE3: seq_state <= next_seq_state;
                default: seq_state <= CH_LOCAL;
            endcase
        end
    end

    assign o_meas_chan = seq_state;

    // ----------------------------------------
    // highest-temperature feed
    // ----------------------------------------
    assign o_ref_temp2 = join_temp(ref2_high, ref2_frac);
    assign o_ref_temp3 = join_temp(ref3_high, ref3_frac);

    // a reading below the reference loads the reference instead
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_highest_load <= 1'b0;
            o_highest_chan <= 4'h0;
            o_highest_value <= '0;
        end else begin
            o_highest_load <= i_meas_valid && (i_meas_chan == CH_REMOTE2 || i_meas_chan == CH_REMOTE3);
            if (i_meas_valid && i_meas_chan == CH_REMOTE2) begin
                o_highest_chan <= i_meas_chan;
                o_highest_value <= (i_meas_temp > o_ref_temp2) ? i_meas_temp : o_ref_temp2;
            end else if (i_meas_valid && i_meas_chan == CH_REMOTE3) begin
                o_highest_chan <= i_meas_chan;
                o_highest_value <= (i_meas_temp > o_ref_temp3) ? i_meas_temp : o_ref_temp3;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence ref2_written;
        i_reg_wr && i_reg_addr == ADDR_REF2_HIGH;
    endsequence
    sequence ref2_read;
        i_reg_rd && i_reg_addr == ADDR_REF2_HIGH;
    endsequence

    AST_REF2_READBACK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (ref2_written ##1 (ref2_read and !i_reg_wr)) |=> (o_reg_rdata == $past(i_reg_wdata, 2)))
        else $error("channel 2 upper reference did not read back");
    AST_LOW_NIBBLE_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_rd && (i_reg_addr == ADDR_REF2_LOW || i_reg_addr == ADDR_REF3_LOW)) |=> (o_reg_rdata[3:0] == 4'h0))
        else $error("reference lower nibble not zero");
    AST_ID_CODES: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == ADDR_MAKER_ID) |=> (o_reg_rvalid && o_reg_rdata == MAKER_CODE))
        else $error("maker identification wrong");
    AST_REV_CODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == ADDR_SILICON_REV) |=> (o_reg_rdata == REVISION_CODE))
        else $error("revision code wrong");
    AST_FORMAT_KEEPS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($changed(i_extended_format) && !i_reg_wr) |=> $stable(o_ref_temp2) && $stable(o_ref_temp3))
        else $error("reference changed on format toggle");
    AST_SKIP_FAULTED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_conv_done && (next_seq_state & {diode_fault, 1'b0}) == 4'h0 && seq_state != next_seq_state)
        |=> ((o_meas_chan & {diode_fault, 1'b0}) == 4'h0 || $changed(diode_fault)))
        else $error("sequence entered a faulted channel");
    AST_FAULT_BIT0: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == ADDR_DIODE_FAULT) |=> (o_reg_rdata[0] == 1'b0 && o_reg_rdata[7:4] == 4'h0))
        else $error("fault status reserved bits set");
    AST_HIGHEST_FLOOR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_meas_valid && i_meas_chan == CH_REMOTE3 && i_meas_temp < o_ref_temp3 && !i_reg_wr)
        |=> (o_highest_load && o_highest_value == o_ref_temp3))
        else $error("highest feed ignored channel 3 reference");
endmodule

// ==== dv/host_model.sv ====
// management-bus host model issuing byte-wide register strobes
// assumes the slice samples strobe, address and data on one rising edge
`timescale 1ns/100ps
module host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_wr,
    output logic o_reg_rd
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
    end

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // released lines show the inverse so a stale value never passes for a match
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_reg_addr <= a;
        o_reg_wdata <= d;
        o_reg_wr <= 1'b1;
        @(posedge i_clk);
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask

    // read strobe right behind the write edge, so the new value must already read back
    task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        o_reg_addr <= a;
        o_reg_wdata <= d;
        o_reg_wr <= 1'b1;
        @(posedge i_clk);
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b1;
        @(posedge i_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
        @(posedge i_clk);
        q = (i_reg_rvalid === 1'b1) ? i_reg_rdata : ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge i_clk);
        o_reg_addr <= a;
        o_reg_rd <= 1'b1;
        @(posedge i_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge i_clk);
            if (i_reg_rvalid === 1'b1) begin
                d = i_reg_rdata;
                ok = 1'b1;
            end
        end
    endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the reference / identification register slice
// assumes host_model drives the register strobes; bench drives sensor-side inputs
`timescale 1ns/100ps
module tb;
    import refid_pkg::*;
    localparam logic [7:0] MAKER = 8'h5a; // value arbitrary
    localparam logic [7:0] REV = 8'h06; // value arbitrary
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid;
    logic ext_fmt = 1'b0;
    logic [3:1] diode_open = 3'h0;
    logic [3:1] diode_short = 3'h0;
    logic [3:0] thermal_fault = 4'h0;
    logic conv_done = 1'b0;
    logic meas_valid = 1'b0;
    logic [3:0] meas_chan = 4'h1;
    logic signed [11:0] meas_temp = 12'h000;
    logic [3:0] cur_chan, high_chan, c;
    logic high_load, alarm, okv;
    logic signed [11:0] high_value, ref2, ref3;
    logic [7:0] rdv;
    int failures = 0;
    int checked = 0;

    always #12.5 i_clk = ~i_clk;

    remote_reference_and_id_regs #(.MAKER_CODE(MAKER), .REVISION_CODE(REV)) DUT (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
        .i_extended_format(ext_fmt), .i_remote_diode_open(diode_open), .i_remote_diode_short(diode_short),
        .i_thermal_fault(thermal_fault), .i_conv_done(conv_done), .i_meas_valid(meas_valid),
        .i_meas_chan(meas_chan), .i_meas_temp(meas_temp), .o_meas_chan(cur_chan), .o_highest_load(high_load),
        .o_highest_chan(high_chan), .o_highest_value(high_value), .o_ref_temp2(ref2), .o_ref_temp3(ref3),
        .o_thermal_alarm_output(alarm));

    host_model host (
        .i_clk(i_clk), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, rdv, okv);
        if (okv !== 1'b1) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h no read answer", $time, rdv, e);
        end else begin
            cmp({4'h0, rdv}, {4'h0, e});
        end
    endtask

    task automatic meas(input logic [3:0] ch, input logic [11:0] t, input logic el, input logic [11:0] ev);
        @(posedge i_clk);
        meas_valid <= 1'b1;
        meas_chan <= ch;
        meas_temp <= t;
        @(posedge i_clk);
        meas_valid <= 1'b0;
        meas_temp <= ~t;
        #1;
        cmp(high_load, el);
        if (el) begin
            cmp(high_value, ev);
            cmp(high_chan, ch);
        end
    endtask

    task automatic step(input logic [3:0] e);
        @(posedge i_clk);
        conv_done <= 1'b1;
        @(posedge i_clk);
        conv_done <= 1'b0;
        #1;
        cmp(cur_chan, e);
    endtask

    task automatic alarm_after(input logic e);
        repeat (2) @(posedge i_clk);
        #1;
        cmp(alarm, e);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, failures);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    // the whole sequence needs well under a thousand cycles
    initial begin
        #(25 * 4000);
        failures++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int a = 8'h44; a <= 8'h47; a++) rd_chk(8'(a), 8'h00);
        rd_chk(ADDR_DIODE_FAULT, 8'h00);
        rd_chk(ADDR_MAKER_ID, MAKER);
        rd_chk(ADDR_SILICON_REV, REV);
        rd_chk(8'h60, READ_UNMAPPED);
        end_test("reset");
        host.write_reg(ADDR_REF2_HIGH, 8'hff);
        host.write_reg(ADDR_REF2_LOW, 8'hff);
        host.write_reg(ADDR_REF3_HIGH, 8'h80);
        host.write_reg(ADDR_REF3_LOW, 8'ha7);
        rd_chk(ADDR_REF2_HIGH, 8'hff);
        rd_chk(ADDR_REF2_LOW, 8'hf0);
        rd_chk(ADDR_REF3_HIGH, 8'h80);
        rd_chk(ADDR_REF3_LOW, 8'ha0);
        cmp(ref2, 12'hfff);
        cmp(ref3, 12'h80a);
        host.write_reg(ADDR_MAKER_ID, 8'h00);
        host.write_reg(ADDR_SILICON_REV, 8'h00);
        rd_chk(ADDR_MAKER_ID, MAKER);
        rd_chk(ADDR_SILICON_REV, REV);
        end_test("registers");
        @(posedge i_clk);
        ext_fmt <= 1'b1;
        rd_chk(ADDR_REF2_HIGH, 8'hff);
        cmp(ref3, 12'h80a);
        host.write_read(ADDR_REF2_HIGH, 8'h20, rdv);
        cmp({4'h0, rdv}, 12'h020);
        host.write_reg(ADDR_REF2_LOW, 8'h00);
        @(posedge i_clk);
        ext_fmt <= 1'b0;
        repeat (2) @(posedge i_clk);
        cmp(ref2, 12'h200);
        end_test("format");
        meas(4'h4, 12'h320, 1'b1, 12'h320);
        meas(4'h4, 12'h100, 1'b1, 12'h200);
        meas(4'h8, 12'h900, 1'b1, 12'h900);
        meas(4'h8, 12'h800, 1'b1, 12'h80a);
        meas(4'h2, 12'h7ff, 1'b0, 12'h000);
        end_test("highest");
        c = 4'h1;
        for (int i = 0; i < 4; i++) begin
            c = {c[2:0], c[3]};
            step(c);
        end
        // unused channels: 3 left open, 2 shorted
        @(posedge i_clk);
        diode_open[3] <= 1'b1;
        diode_short[2] <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd_chk(ADDR_DIODE_FAULT, 8'h0c);
        step(4'h2);
        step(4'h1);
        alarm_after(1'b1);
        host.write_reg(ADDR_ALARM_MASK, 8'h0c);
        alarm_after(1'b0);
        @(posedge i_clk);
        thermal_fault[1] <= 1'b1;
        alarm_after(1'b1);
        host.write_reg(ADDR_ALARM_MASK, 8'h0e);
        alarm_after(1'b0);
        @(posedge i_clk);
        diode_open <= 3'h0;
        diode_short <= 3'h0;
        repeat (4) @(posedge i_clk);
        host.write_reg(ADDR_DIODE_FAULT, 8'h00);
        rd_chk(ADDR_DIODE_FAULT, 8'h00);
        // channel 2 disabled: no detection on it and the sequence passes it by
        host.write_reg(ADDR_CHAN_ENABLE, 8'h0b);
        rd_chk(ADDR_CHAN_ENABLE, 8'h0b);
        @(posedge i_clk);
        diode_short[2] <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd_chk(ADDR_DIODE_FAULT, 8'h00);
        step(4'h2);
        step(4'h8);
        end_test("faults");
        tally_and_finish();
    end
endmodule
